/* common/rtc_pkg.sv */
// constants, register map and carrier types of the calendar clock
package rtc_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0] ADDR_SECS      = 8'hE0;
  localparam logic [7:0] ADDR_MIN       = 8'hE1;
  localparam logic [7:0] ADDR_HRS       = 8'hE2;
  localparam logic [7:0] ADDR_DOW       = 8'hE3;
  localparam logic [7:0] ADDR_DOM       = 8'hE4;
  localparam logic [7:0] ADDR_MON       = 8'hE5;
  localparam logic [7:0] ADDR_YR        = 8'hE6;
  localparam logic [7:0] ADDR_CEN       = 8'hE7;
  localparam logic [7:0] ADDR_ALM_SECS  = 8'hE8;
  localparam logic [7:0] ADDR_ALM_MIN   = 8'hE9;
  localparam logic [7:0] ADDR_ALM_HRS   = 8'hEA;
  localparam logic [7:0] ADDR_ALM_DOW   = 8'hEB;
  localparam logic [7:0] ADDR_ALM_CTRL  = 8'hEC;
  localparam logic [7:0] ADDR_CTRL      = 8'hED;
  // control register fields
  localparam int unsigned CTRL_FLAG_BIT   = 7;
  localparam int unsigned CTRL_IRQEN_BIT  = 5;
  localparam int unsigned CTRL_BCD_BIT    = 4;
  localparam int unsigned CTRL_SRC_BIT    = 3;
  localparam int unsigned CTRL_F50_BIT    = 2;
  localparam int unsigned CTRL_UNLOCK_BIT = 0;
  // alarm enable fields
  localparam int unsigned AEN_SECS_BIT = 0;
  localparam int unsigned AEN_MIN_BIT = 1;
  localparam int unsigned AEN_HRS_BIT = 2;
  localparam int unsigned AEN_DOW_BIT = 3;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [3:0] AEN_RESET    = 4'h0;
  // time base divisors
  localparam int unsigned OSC_DIVIDE  = 32768;
  localparam int unsigned LINE50_DIV  = 50;
  localparam int unsigned LINE60_DIV  = 60;
  localparam int unsigned DIV_W       = 16;
  // count limits, binary
  localparam logic [7:0] SECS_MAX = 8'h3B;
  localparam logic [7:0] MIN_MAX = 8'h3B;
  localparam logic [7:0] HRS_MAX = 8'h17;
  localparam logic [7:0] DOW_MAX = 8'h07;
  localparam logic [7:0] MON_MAX = 8'h0C;
  localparam logic [7:0] YR_MAX  = 8'h63;
  localparam logic [7:0] CEN_MAX = 8'h63;
  localparam logic [7:0] FIRST_DAY = 8'h01;

  typedef struct packed {
    logic [7:0] cen;
    logic [7:0] yr;
    logic [7:0] mon;
    logic [7:0] dom;
    logic [7:0] dow;
    logic [7:0] hrs;
    logic [7:0] min;
    logic [7:0] secs;
  } time_s;

  typedef struct packed {
    logic [7:0] secs;
    logic [7:0] min;
    logic [7:0] hrs;
    logic [7:0] dow;
    logic [3:0] en;
  } alarm_s;
endpackage

/* src/calendar_clock_with_alarm.sv */
// calendar clock: counters, time-base divider, alarm, cpu register port
`timescale 1ns/1ps
`default_nettype none

module calendar_clock_with_alarm #(
  parameter int unsigned OSC_DIVIDE = rtc_pkg::OSC_DIVIDE,
  parameter int unsigned LINE50_DIV = rtc_pkg::LINE50_DIV,
  parameter int unsigned LINE60_DIV = rtc_pkg::LINE60_DIV
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      srst_in,
  input  wire logic [rtc_pkg::ADDR_W-1:0] io_addr_in,
  input  wire logic                      io_wr_in,
  input  wire logic                      io_rd_in,
  input  wire logic [7:0]                io_wdata_in,
  input  wire logic                      osc_32k_in,
  input  wire logic                      crystal_output_pin_in,
  output logic      [7:0]                io_rdata_out,
  output logic                           alarm_irq_out
);

  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
    to_bin = bcd ? 8'({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]}) : v;
  endfunction

  function automatic logic [7:0] from_bin(input logic [7:0] b, input logic bcd);
    from_bin = bcd ? {4'(b / 8'h0A), 4'(b % 8'h0A)} : b;
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr, input logic bcd);
    unique case (mon)
      8'h02:                      month_days = (bcd && yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: month_days = 8'h1E;
      default:                    month_days = 8'h1F;
    endcase
  endfunction

  rtc_pkg::time_s  time_q;
  rtc_pkg::time_s  time_d;
  rtc_pkg::alarm_s alarm_q;
  logic [7:0]      ctrl_q;
  logic            flag_q;
  logic            flag_d;
  logic [2:0]      osc_sync_q;
  logic [2:0]      line_sync_q;
  logic [rtc_pkg::DIV_W-1:0] div_q;
  logic [rtc_pkg::DIV_W-1:0] div_limit;
  logic            src_edge;
  logic            tick;
  logic            cmp_req_q;
  logic            alarm_hit;
  logic            bcd;
  logic            unlocked;
  logic            wr_ctrl;
  logic            rd_ctrl;
  logic            wr_count;
  logic [7:0]      rd_mux;

  assign bcd      = ctrl_q[rtc_pkg::CTRL_BCD_BIT];
  assign unlocked = ctrl_q[rtc_pkg::CTRL_UNLOCK_BIT];
  assign wr_ctrl  = io_wr_in && io_addr_in == rtc_pkg::ADDR_CTRL;
  assign rd_ctrl  = io_rd_in && io_addr_in == rtc_pkg::ADDR_CTRL;
  assign wr_count = io_wr_in && unlocked && io_addr_in >= rtc_pkg::ADDR_SECS
                    && io_addr_in <= rtc_pkg::ADDR_CEN;

  // pin inputs: two stages, third stage only for edge detect
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      osc_sync_q  <= 3'h0;
      line_sync_q <= 3'h0;
    end else begin
      osc_sync_q  <= {osc_sync_q[1:0], osc_32k_in};
      line_sync_q <= {line_sync_q[1:0], crystal_output_pin_in};
    end
  end

  localparam int unsigned DIV_W = rtc_pkg::DIV_W;

  always_comb begin
    if (ctrl_q[rtc_pkg::CTRL_SRC_BIT]) begin
      src_edge  = line_sync_q[1] && !line_sync_q[2];
      div_limit = ctrl_q[rtc_pkg::CTRL_F50_BIT] ? DIV_W'(LINE50_DIV) : DIV_W'(LINE60_DIV);
    end else begin
      src_edge  = osc_sync_q[1] && !osc_sync_q[2];
      div_limit = DIV_W'(OSC_DIVIDE);
    end
  end

  assign tick = src_edge && !unlocked && div_q == div_limit - DIV_W'(1);

  // divider: held while unlocked, restarted by any control write
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_q <= '0;
    end else if (wr_ctrl || unlocked) begin
      div_q <= '0;
    end else if (src_edge) begin
      div_q <= tick ? '0 : div_q + DIV_W'(1);
    end
  end

  // next calendar value for one tick
  always_comb begin
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic [7:0] w;
    logic [7:0] d;
    logic [7:0] mo;
    logic [7:0] y;
    logic [7:0] c;
    logic       cy;
    s  = to_bin(time_q.secs, bcd);
    m  = to_bin(time_q.min, bcd);
    h  = to_bin(time_q.hrs, bcd);
    w  = time_q.dow;
    d  = to_bin(time_q.dom, bcd);
    mo = to_bin(time_q.mon, bcd);
    y  = to_bin(time_q.yr, bcd);
    c  = to_bin(time_q.cen, bcd);
    cy = s >= rtc_pkg::SECS_MAX;
    s  = cy ? 8'h00 : s + 8'h01;
    if (cy) begin
      cy = m >= rtc_pkg::MIN_MAX;
      m  = cy ? 8'h00 : m + 8'h01;
    end
    if (cy) begin
      cy = h >= rtc_pkg::HRS_MAX;
      h  = cy ? 8'h00 : h + 8'h01;
    end
    if (cy) begin
      w  = (w >= rtc_pkg::DOW_MAX) ? rtc_pkg::FIRST_DAY : w + 8'h01;
      cy = d >= month_days(mo, y, bcd);
      d  = cy ? rtc_pkg::FIRST_DAY : d + 8'h01;
    end
    if (cy) begin
      cy = mo >= rtc_pkg::MON_MAX;
      mo = cy ? rtc_pkg::FIRST_DAY : mo + 8'h01;
    end
    if (cy) begin
      cy = y >= rtc_pkg::YR_MAX;
      y  = cy ? 8'h00 : y + 8'h01;
    end
    if (cy) begin
      c = (c >= rtc_pkg::CEN_MAX) ? 8'h00 : c + 8'h01;
    end
    time_d.secs = from_bin(s, bcd);
    time_d.min = from_bin(m, bcd);
    time_d.hrs = from_bin(h, bcd);
    time_d.dow = {4'h0, w[3:0]};
    time_d.dom = from_bin(d, bcd);
    time_d.mon = from_bin(mo, bcd);
    time_d.yr  = from_bin(y, bcd);
    time_d.cen = from_bin(c, bcd);
  end

  // counts carry no reset: contents survive a system reset
  always_ff @(posedge core_clk_in) begin
    if (wr_count) begin
      unique case (io_addr_in)
        rtc_pkg::ADDR_SECS: time_q.secs <= io_wdata_in;
        rtc_pkg::ADDR_MIN: time_q.min <= io_wdata_in;
        rtc_pkg::ADDR_HRS: time_q.hrs <= io_wdata_in;
        rtc_pkg::ADDR_DOW: time_q.dow <= {4'h0, io_wdata_in[3:0]};
        rtc_pkg::ADDR_DOM: time_q.dom <= io_wdata_in;
        rtc_pkg::ADDR_MON: time_q.mon <= io_wdata_in;
        rtc_pkg::ADDR_YR:  time_q.yr  <= io_wdata_in;
        default:           time_q.cen <= io_wdata_in;
      endcase
    end else if (tick) begin
      time_q <= time_d;
    end
  end

  // control register; reset comes up locked
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctrl_q <= rtc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= io_wdata_in;
    end
  end

  // alarm registers, writable regardless of lock
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      alarm_q.en <= rtc_pkg::AEN_RESET;
    end else if (io_wr_in) begin
      unique case (io_addr_in)
        rtc_pkg::ADDR_ALM_SECS: alarm_q.secs <= io_wdata_in;
        rtc_pkg::ADDR_ALM_MIN:  alarm_q.min <= io_wdata_in;
        rtc_pkg::ADDR_ALM_HRS:  alarm_q.hrs <= io_wdata_in;
        rtc_pkg::ADDR_ALM_DOW:  alarm_q.dow <= {4'h0, io_wdata_in[3:0]};
        rtc_pkg::ADDR_ALM_CTRL: alarm_q.en  <= io_wdata_in[3:0];
        default: ;
      endcase
    end
  end

  // comparison request: after each increment or a lock write
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cmp_req_q <= 1'b0;
    end else begin
      cmp_req_q <= tick || (wr_ctrl && !io_wdata_in[rtc_pkg::CTRL_UNLOCK_BIT]);
    end
  end

  assign alarm_hit = cmp_req_q && (|alarm_q.en)
    && (!alarm_q.en[rtc_pkg::AEN_SECS_BIT] || alarm_q.secs == time_q.secs)
    && (!alarm_q.en[rtc_pkg::AEN_MIN_BIT] || alarm_q.min == time_q.min)
    && (!alarm_q.en[rtc_pkg::AEN_HRS_BIT] || alarm_q.hrs == time_q.hrs)
    && (!alarm_q.en[rtc_pkg::AEN_DOW_BIT] || alarm_q.dow == time_q.dow);

  // a match in the clearing cycle keeps the flag set
  assign flag_d = alarm_hit || (flag_q && !rd_ctrl);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flag_q        <= 1'b0;
      alarm_irq_out <= 1'b0;
    end else begin
      flag_q        <= flag_d;
      alarm_irq_out <= flag_d && ctrl_q[rtc_pkg::CTRL_IRQEN_BIT];
    end
  end

  always_comb begin
    unique case (io_addr_in)
      rtc_pkg::ADDR_SECS:     rd_mux = time_q.secs;
      rtc_pkg::ADDR_MIN:      rd_mux = time_q.min;
      rtc_pkg::ADDR_HRS:      rd_mux = time_q.hrs;
      rtc_pkg::ADDR_DOW:      rd_mux = {4'h0, time_q.dow[3:0]};
      rtc_pkg::ADDR_DOM:      rd_mux = time_q.dom;
      rtc_pkg::ADDR_MON:      rd_mux = time_q.mon;
      rtc_pkg::ADDR_YR:       rd_mux = time_q.yr;
      rtc_pkg::ADDR_CEN:      rd_mux = time_q.cen;
      rtc_pkg::ADDR_ALM_SECS: rd_mux = alarm_q.secs;
      rtc_pkg::ADDR_ALM_MIN:  rd_mux = alarm_q.min;
      rtc_pkg::ADDR_ALM_HRS:  rd_mux = alarm_q.hrs;
      rtc_pkg::ADDR_ALM_DOW:  rd_mux = alarm_q.dow;
      rtc_pkg::ADDR_ALM_CTRL: rd_mux = {4'h0, alarm_q.en};
      rtc_pkg::ADDR_CTRL:     rd_mux = {flag_q, ctrl_q[6:0]};
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_out <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_lock_write;
    wr_ctrl && !io_wdata_in[rtc_pkg::CTRL_UNLOCK_BIT];
  endsequence

  sequence s_compare;
    cmp_req_q;
  endsequence

  property p_lock_compares;
    s_lock_write |=> s_compare;
  endproperty
  a_lock_compares: assert property (p_lock_compares) else $error("lock write did not compare");

  property p_tick_compares;
    tick |=> s_compare;
  endproperty
  a_tick_compares: assert property (p_tick_compares) else $error("increment without compare");

  property p_hit_flags;
    alarm_hit |=> flag_q;
  endproperty
  a_hit_flags: assert property (p_hit_flags) else $error("alarm match lost");

  property p_irq_gated;
    alarm_irq_out |-> flag_q && $past(ctrl_q[rtc_pkg::CTRL_IRQEN_BIT]);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without flag or enable");

  property p_read_clears;
    rd_ctrl && !alarm_hit |=> !flag_q && !alarm_irq_out;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("control read did not clear");

  property p_locked_hold;
    !unlocked && !tick |=> $stable(time_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked counts changed");

  property p_unlocked_stop;
    unlocked && !wr_count |=> $stable(time_q);
  endproperty
  a_unlocked_stop: assert property (p_unlocked_stop) else $error("counted while unlocked");

  property p_ctrl_resets_div;
    wr_ctrl |=> div_q == '0;
  endproperty
  a_ctrl_resets_div: assert property (p_ctrl_resets_div) else $error("divider not reset");

  property p_secs_wrap;
    tick && !bcd && time_q.secs == rtc_pkg::SECS_MAX |=> time_q.secs == 8'h00;
  endproperty
  a_secs_wrap: assert property (p_secs_wrap) else $error("seconds did not wrap");

  property p_dow_upper;
    io_rd_in && io_addr_in == rtc_pkg::ADDR_DOW |=> io_rdata_out[7:4] == 4'h0;
  endproperty
  a_dow_upper: assert property (p_dow_upper) else $error("weekday upper nibble set");

  property p_unlock_holds_div;
    unlocked |=> div_q == '0;
  endproperty
  a_unlock_holds_div: assert property (p_unlock_holds_div) else $error("divider ran while unlocked");

endmodule

`default_nettype wire

/* testbench/host_bus_model.sv */
// host cpu model driving the register port of the calendar clock
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] io_rdata_in,
  output var logic  [7:0] io_addr_out,
  output var logic        io_wr_out,
  output var logic        io_rd_out,
  output var logic  [7:0] io_wdata_out
);
  initial begin
    io_addr_out  = 8'h00;
    io_wr_out    = 1'b0;
    io_rd_out    = 1'b0;
    io_wdata_out = 8'h00;
  end

  // one-cycle write strobe; address and data flip once released
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk_in);
    io_addr_out  = addr;
    io_wdata_out = data;
    io_wr_out    = 1'b1;
    @(negedge core_clk_in);
    io_wr_out    = 1'b0;
    io_addr_out  = ~addr;
    io_wdata_out = ~data;
  endtask

  // one-cycle read strobe; data is taken one edge later
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk_in);
    io_addr_out = addr;
    io_rd_out   = 1'b1;
    @(negedge core_clk_in);
    io_rd_out   = 1'b0;
    io_addr_out = ~addr;
    data        = io_rdata_in;
  endtask
endmodule

`default_nettype wire

/* testbench/tb_calendar_clock_with_alarm.sv */
// self-checking bench for the calendar clock with alarm
`timescale 1ns/1ps
`default_nettype none

module tb_calendar_clock_with_alarm;
  localparam int unsigned OSC_N = 4;
  logic       core_clk_in = 1'b0;
  logic       srst_in     = 1'b1;
  logic       osc         = 1'b0;
  logic       line        = 1'b0;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq;
  int         fails       = 0;
  int         checked     = 0;

  always #2.5 core_clk_in = ~core_clk_in;

  calendar_clock_with_alarm #(.OSC_DIVIDE(OSC_N), .LINE50_DIV(50), .LINE60_DIV(60))
    calendar_clock_with_alarm_inst (
    .core_clk_in           (core_clk_in),
    .srst_in               (srst_in),
    .io_addr_in            (addr),
    .io_wr_in              (wr),
    .io_rd_in              (rd),
    .io_wdata_in           (wdata),
    .osc_32k_in            (osc),
    .crystal_output_pin_in (line),
    .io_rdata_out          (rdata),
    .alarm_irq_out         (irq)
  );

  host_bus_model host_bus_model_inst (
    .core_clk_in  (core_clk_in),
    .io_rdata_in  (rdata),
    .io_addr_out  (addr),
    .io_wr_out    (wr),
    .io_rd_out    (rd),
    .io_wdata_out (wdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_inst.wr(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_bus_model_inst.rd(a, d);
    check(d, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (4) @(negedge core_clk_in);
    check({7'h00, irq}, {7'h00, exp});
  endtask

  // rising edges on the chosen time-base pin, still between bursts
  task automatic pulses(input int n, input logic use_line);
    repeat (n) begin
      @(negedge core_clk_in);
      if (use_line) line = 1'b1; else osc = 1'b1;
      repeat (8) @(negedge core_clk_in);
      line = 1'b0;
      osc  = 1'b0;
      repeat (8) @(negedge core_clk_in);
    end
    repeat (4) @(negedge core_clk_in);
  endtask

  task automatic t_calendar;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h01);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h3B);
    wr_reg(rtc_pkg::ADDR_MIN, 8'h3B);
    wr_reg(rtc_pkg::ADDR_HRS, 8'h17);
    wr_reg(rtc_pkg::ADDR_DOW, 8'hF7);
    wr_reg(rtc_pkg::ADDR_DOM, 8'h1C);
    wr_reg(rtc_pkg::ADDR_MON, 8'h02);
    wr_reg(rtc_pkg::ADDR_YR, 8'h04);
    wr_reg(rtc_pkg::ADDR_CEN, 8'h14);
    rd_chk(rtc_pkg::ADDR_DOW, 8'h07);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    pulses(OSC_N, 1'b0);
    rd_chk(rtc_pkg::ADDR_HRS, 8'h00);
    rd_chk(rtc_pkg::ADDR_DOW, 8'h01);
    rd_chk(rtc_pkg::ADDR_DOM, 8'h01);
    rd_chk(rtc_pkg::ADDR_MON, 8'h03);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h11);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h59);
    wr_reg(rtc_pkg::ADDR_MIN, 8'h59);
    wr_reg(rtc_pkg::ADDR_HRS, 8'h23);
    wr_reg(rtc_pkg::ADDR_DOW, 8'h03);
    wr_reg(rtc_pkg::ADDR_DOM, 8'h28);
    wr_reg(rtc_pkg::ADDR_MON, 8'h02);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h10);
    pulses(OSC_N, 1'b0);
    rd_chk(rtc_pkg::ADDR_HRS, 8'h00);
    rd_chk(rtc_pkg::ADDR_DOW, 8'h04);
    rd_chk(rtc_pkg::ADDR_DOM, 8'h29);
    rd_chk(rtc_pkg::ADDR_MON, 8'h02);
  endtask

  task automatic t_lock;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h01);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h3B);
    wr_reg(rtc_pkg::ADDR_MIN, 8'h05);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h3B);
    rd_chk(rtc_pkg::ADDR_MIN, 8'h05);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h10);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h3B);
    pulses(OSC_N, 1'b0);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h00);
    rd_chk(rtc_pkg::ADDR_MIN, 8'h06);
  endtask

  task automatic t_bcd;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h11);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h59);
    wr_reg(rtc_pkg::ADDR_MIN, 8'h09);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h10);
    pulses(OSC_N, 1'b0);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h00);
    rd_chk(rtc_pkg::ADDR_MIN, 8'h10);
  endtask

  task automatic t_divider;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h01);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h00);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    pulses(OSC_N - 1, 1'b0);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h00);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    pulses(OSC_N - 1, 1'b0);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h00);
    pulses(1, 1'b0);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h01);
  endtask

  // 50 Hz then 60 Hz line source
  task automatic t_line;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h0D);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h00);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h0C);
    pulses(49, 1'b1);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h00);
    pulses(1, 1'b1);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h01);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h08);
    pulses(59, 1'b1);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h01);
    pulses(1, 1'b1);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h02);
  endtask

  task automatic t_alarm;
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    wr_reg(rtc_pkg::ADDR_ALM_SECS, 8'h02);
    wr_reg(rtc_pkg::ADDR_ALM_CTRL, 8'h01);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h20);
    irq_chk(1'b1);
    rd_chk(rtc_pkg::ADDR_CTRL, 8'hA0);
    irq_chk(1'b0);
    rd_chk(rtc_pkg::ADDR_CTRL, 8'h20);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h00);
    irq_chk(1'b0);
    rd_chk(rtc_pkg::ADDR_CTRL, 8'h80);
    wr_reg(rtc_pkg::ADDR_ALM_MIN, 8'h00);
    wr_reg(rtc_pkg::ADDR_ALM_CTRL, 8'h03);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h20);
    irq_chk(1'b0);
    rd_chk(rtc_pkg::ADDR_CTRL, 8'h20);
    wr_reg(rtc_pkg::ADDR_ALM_CTRL, 8'h01);
    wr_reg(rtc_pkg::ADDR_ALM_SECS, 8'h03);
    wr_reg(rtc_pkg::ADDR_CTRL, 8'h20);
    irq_chk(1'b0);
    pulses(OSC_N, 1'b0);
    check({7'h00, irq}, 8'h01);
  endtask

  task automatic t_reset;
    @(negedge core_clk_in);
    srst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    srst_in = 1'b0;
    check({7'h00, irq}, 8'h00);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h03);
    rd_chk(rtc_pkg::ADDR_CTRL, 8'h00);
    rd_chk(rtc_pkg::ADDR_ALM_CTRL, 8'h00);
    wr_reg(rtc_pkg::ADDR_SECS, 8'h30);
    rd_chk(rtc_pkg::ADDR_SECS, 8'h03);
  endtask

  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge core_clk_in);
    srst_in = 1'b0;
    rd_chk(rtc_pkg::ADDR_CTRL, 8'h00);
    rd_chk(8'hF0, 8'h00);
    t_calendar();
    t_lock();
    t_bcd();
    t_divider();
    t_line();
    t_alarm();
    t_reset();
    finish_test();
  end

  // run needs about 2600 cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule

`default_nettype wire
